// ==== hdl/adr_decode.sv ====
// Address decoder with vector overlay, peripheral slot select and abort generation
// How it works
// - Each peripheral bus: 128 slots of 16 KB
// - Peripheral size check aborts only when the access is both narrower than a word and not word aligned
// - Vectors occupy eight words at address zero
// - Reset forces boot loader mapping mode
// - User flash mode: no overlay
// - User RAM mode overlays SRAM bottom
// - Overlay covers 64 bytes from zero
// - Overlaid memory also stays at home address
// - Boot block fixed at top of on-chip memory
// - Reserved gaps and empty slots abort always
// - External memory region always aborts
// - Fetch from any peripheral region aborts
// - Undefined slow-bus slot offsets complete normally
// - Peripherals decode only needed register bits
module adr_decode
   import adr_pkg::*;
#(
   parameter logic [31:0] FLASH_SIZE = adr_pkg::FLASH_SIZE_DEF,
   parameter logic [31:0] SRAM_SIZE = adr_pkg::SRAM_SIZE_DEF,
   parameter logic [127:0] SLOW_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_FFFF,
   parameter logic [127:0] FAST_MASK = 128'h8000_0000_0000_0000_0000_0000_0000_0000,
   parameter int REG_BITS = 6
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Mapping mode control
   input wire logic map_wr,
   input wire logic [1:0] map_wdata,
   output logic [1:0] map_mode,
   // Core request
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_fetch,
   input wire logic [1:0] req_size,
   input wire logic [31:0] req_addr,
   // Decoded access to memories and peripherals
   output logic sel_flash,
   output logic sel_sram,
   output logic sel_boot,
   output logic sel_slowp,
   output logic sel_fastp,
   output logic [6:0] sel_slot,
   output logic [31:0] sel_addr,
   output logic sel_write,
   // Abort answer
   output logic data_abort,
   output logic prefetch_abort
);
   logic [1:0] mode_reg, mode_next;
   logic [31:0] eff_addr;
   adr_tgt_t tgt;
   logic fast_bus;
   logic slot_ok;
   logic sel_flash_reg, sel_sram_reg, sel_boot_reg, sel_slowp_reg, sel_fastp_reg, sel_write_reg;
   logic sel_flash_next, sel_sram_next, sel_boot_next, sel_slowp_next, sel_fastp_next, sel_write_next;
   logic [6:0] slot_reg, slot_next;
   logic [31:0] addr_reg, addr_next;
   logic periph_pend_reg, periph_pend_next;
   logic fetch_pend_reg, fetch_pend_next;
   logic size_bad_reg, size_bad_next;
   logic dab_reg, dab_next, pab_reg, pab_next;
   logic [6:0] lookup_slot;

   function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [31:0] pbus_offset(input logic [31:0] a, input int bits);
      logic [31:0] m;
      m = (32'h1 << (bits + WORD_LSB)) - 32'h1;
      pbus_offset = a & m & ~32'h3;
   endfunction

   always_comb
   begin
      mode_next = mode_reg;
      if (map_wr && (map_wdata <= MAP_RAM))
         mode_next = map_wdata;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         mode_reg <= MAP_BOOT;
      else
         mode_reg <= mode_next;
   end

   // Overlay redirects only the low 64 bytes; home addresses stay decoded too
   always_comb
   begin
      eff_addr = req_addr;
      if (req_addr <= OVL_LAST)
      begin
         case (mode_reg)
            MAP_BOOT: eff_addr = BOOT_BASE | {26'h0, req_addr[OVL_W-1:0]};
            MAP_FLASH: eff_addr = req_addr;
            MAP_RAM: eff_addr = SRAM_BASE | {26'h0, req_addr[OVL_W-1:0]};
            default: eff_addr = req_addr;
         endcase
      end
   end

   // Region decode; boot block wins over the reserved gaps below it
   always_comb
   begin
      tgt = TGT_NONE;
      fast_bus = 1'b0;
      if (in_rng(eff_addr, BOOT_BASE, BOOT_TOP))
         tgt = TGT_BOOT;
      else if (in_rng(eff_addr, FLASH_BASE, FLASH_SIZE - 32'h1))
         tgt = TGT_FLASH;
      else if (in_rng(eff_addr, SRAM_BASE, SRAM_BASE + SRAM_SIZE - 32'h1))
         tgt = TGT_SRAM;
      else if (in_rng(eff_addr, EXT_BASE, EXT_TOP))
         tgt = TGT_NONE;
      else if (in_rng(eff_addr, SLOWP_BASE, SLOWP_BASE + (32'h1 << PBUS_SPAN_W) - 32'h1))
         tgt = TGT_SLOWP;
      else if (eff_addr >= FASTP_BASE)
      begin
         tgt = TGT_FASTP;
         fast_bus = 1'b1;
      end
   end

   assign lookup_slot = eff_addr[SLOT_LSB +: SLOT_W];

   adr_slot_map #(
      .SLOTS(NUM_SLOTS),
      .SLOW_MASK(SLOW_MASK),
      .FAST_MASK(FAST_MASK)
   ) u_slot_map (
      .ref_clk(ref_clk),
      .rst(rst),
      .slot(lookup_slot),
      .fast_bus(fast_bus),
      .assigned(slot_ok)
   );

   // Selects are registered with the lookup so both reach the targets in the same cycle
   always_comb
   begin
      sel_flash_next = 1'b0;
      sel_sram_next = 1'b0;
      sel_boot_next = 1'b0;
      sel_slowp_next = 1'b0;
      sel_fastp_next = 1'b0;
      sel_write_next = 1'b0;
      periph_pend_next = 1'b0;
      fetch_pend_next = 1'b0;
      size_bad_next = 1'b0;
      slot_next = lookup_slot;
      addr_next = eff_addr;
      dab_next = 1'b0;
      pab_next = 1'b0;
      if (req_valid)
      begin
         sel_write_next = req_write;
         fetch_pend_next = req_fetch;
         case (tgt)
            TGT_FLASH: sel_flash_next = 1'b1;
            TGT_SRAM: sel_sram_next = 1'b1;
            TGT_BOOT: sel_boot_next = 1'b1;
            TGT_SLOWP, TGT_FASTP:
            begin
               periph_pend_next = 1'b1;
               sel_slowp_next = (tgt == TGT_SLOWP);
               sel_fastp_next = (tgt == TGT_FASTP);
               // Only the register-select bits reach the peripheral; higher offset bits alias
               addr_next = pbus_offset(eff_addr, REG_BITS);
               size_bad_next = (req_size != SZ_WORD) && (req_addr[1:0] != 2'h0);
            end
            default:
            begin
               // Aborted write must not reach any target
               sel_write_next = 1'b0;
               dab_next = ~req_fetch;
               pab_next = req_fetch;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sel_flash_reg <= 1'b0;
         sel_sram_reg <= 1'b0;
         sel_boot_reg <= 1'b0;
         sel_slowp_reg <= 1'b0;
         sel_fastp_reg <= 1'b0;
         sel_write_reg <= 1'b0;
         periph_pend_reg <= 1'b0;
         fetch_pend_reg <= 1'b0;
         size_bad_reg <= 1'b0;
         slot_reg <= 7'h00;
         addr_reg <= 32'h0000_0000;
         dab_reg <= 1'b0;
         pab_reg <= 1'b0;
      end
      else
      begin
         sel_flash_reg <= sel_flash_next;
         sel_sram_reg <= sel_sram_next;
         sel_boot_reg <= sel_boot_next;
         sel_slowp_reg <= sel_slowp_next;
         sel_fastp_reg <= sel_fastp_next;
         sel_write_reg <= sel_write_next;
         periph_pend_reg <= periph_pend_next;
         fetch_pend_reg <= fetch_pend_next;
         size_bad_reg <= size_bad_next;
         slot_reg <= slot_next;
         addr_reg <= addr_next;
         dab_reg <= dab_next;
         pab_reg <= pab_next;
      end
   end

   // Peripheral strobes gated by slot table, fetch and size check; aborted access strobes nothing
   logic periph_ok;
   assign periph_ok = periph_pend_reg && slot_ok && !fetch_pend_reg && !size_bad_reg;

   assign map_mode = mode_reg;
   assign sel_flash = sel_flash_reg;
   assign sel_sram = sel_sram_reg;
   assign sel_boot = sel_boot_reg;
   assign sel_slowp = sel_slowp_reg && periph_ok;
   assign sel_fastp = sel_fastp_reg && periph_ok;
   assign sel_slot = slot_reg;
   assign sel_addr = addr_reg;
   assign sel_write = sel_write_reg && (!periph_pend_reg || periph_ok);
   assign data_abort = dab_reg || (periph_pend_reg && !fetch_pend_reg && (!slot_ok || size_bad_reg));
   assign prefetch_abort = pab_reg || (periph_pend_reg && fetch_pend_reg);
endmodule

// ==== hdl/adr_pkg.sv ====
// Package: address map, region decode constants and mapping modes of the address decoder
package adr_pkg;
   localparam int ADDR_W = 32;
   localparam int SLOT_W = 7;
   localparam int NUM_SLOTS = 128;
   // Region bases and limits (inclusive)
   localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
   localparam logic [31:0] FLASH_SIZE_DEF = 32'h0002_0000;
   localparam logic [31:0] BOOT_BASE = 32'h7FFF_E000;
   localparam logic [31:0] BOOT_TOP = 32'h7FFF_FFFF;
   localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
   localparam logic [31:0] SRAM_SIZE_DEF = 32'h0001_0000;
   localparam logic [31:0] SRAM_LIMIT = 32'h7FFF_FFFF;
   localparam logic [31:0] EXT_BASE = 32'h8000_0000;
   localparam logic [31:0] EXT_TOP = 32'hDFFF_FFFF;
   localparam logic [31:0] SLOWP_BASE = 32'hE000_0000;
   localparam logic [31:0] FASTP_BASE = 32'hFFE0_0000;
   // Peripheral bus region: 2 MB, 128 slots of 16 KB
   localparam int PBUS_SPAN_W = 21;
   localparam int SLOT_LSB = 14;
   localparam int WORD_LSB = 2;
   // Vector overlay window: 64 bytes
   localparam int OVL_W = 6;
   localparam logic [31:0] VEC_LAST = 32'h0000_001C;
   localparam logic [31:0] OVL_LAST = 32'h0000_003F;
   // Access sizes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   // Mapping mode field encoding
   localparam logic [1:0] MAP_BOOT = 2'h0;
   localparam logic [1:0] MAP_FLASH = 2'h1;
   localparam logic [1:0] MAP_RAM = 2'h2;
   // Decoded targets, one-hot
   typedef enum logic [5:0]
   {
      TGT_NONE = 6'h01,
      TGT_FLASH = 6'h02,
      TGT_SRAM = 6'h04,
      TGT_BOOT = 6'h08,
      TGT_SLOWP = 6'h10,
      TGT_FASTP = 6'h20
   } adr_tgt_t;
endpackage

// ==== hdl/adr_slot_map.sv ====
// Table of assigned peripheral slots, one bit per slot, with registered lookup
module adr_slot_map #(
   parameter int SLOTS = 128,
   parameter logic [127:0] SLOW_MASK = 128'h0,
   parameter logic [127:0] FAST_MASK = 128'h0
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Lookup
   input wire logic [6:0] slot,
   input wire logic fast_bus,
   output logic assigned
);
   logic assigned_next;
   always_comb
   begin
      assigned_next = fast_bus ? FAST_MASK[slot] : SLOW_MASK[slot];
   end
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         assigned <= 1'b0;
      else
         assigned <= assigned_next;
   end
endmodule

// ==== tb/adr_decode_asserts.sv ====
// Checker: answer timing, overlay and abort relations of the decoder
module adr_decode_asserts
   import adr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Mode and request
   input wire logic map_wr,
   input wire logic [1:0] map_wdata,
   input wire logic [1:0] map_mode,
   input wire logic req_valid,
   input wire logic req_fetch,
   input wire logic [31:0] req_addr,
   // Answer
   input wire logic sel_flash,
   input wire logic sel_sram,
   input wire logic sel_boot,
   input wire logic sel_slowp,
   input wire logic sel_fastp,
   input wire logic [31:0] sel_addr,
   input wire logic sel_write,
   input wire logic data_abort,
   input wire logic prefetch_abort
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [6:0] res = {sel_flash, sel_sram, sel_boot, sel_slowp, sel_fastp, data_abort, prefetch_abort};
   wire ovl = req_valid && req_addr <= OVL_LAST;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   a_reset_boot: assert property ($fell(rst) |-> map_mode == MAP_BOOT)
      else $error("mode not boot after reset");
   a_mode_write: assert property (map_wr && map_wdata != 2'h3 |=> map_mode == $past(map_wdata))
      else $error("mode write lost");
   a_mode_ignore: assert property (map_wr && map_wdata == 2'h3 |=> $stable(map_mode))
      else $error("illegal mode taken");
   a_boot_overlay: assert property (
      ovl && map_mode == MAP_BOOT |=> sel_boot && sel_addr == (BOOT_BASE | $past(req_addr)))
      else $error("boot overlay wrong");
   a_flash_direct: assert property (
      ovl && map_mode == MAP_FLASH |=> sel_flash && sel_addr == $past(req_addr))
      else $error("flash vectors remapped");
   a_ram_overlay: assert property (
      ovl && map_mode == MAP_RAM |=> sel_sram && sel_addr == (SRAM_BASE | $past(req_addr)))
      else $error("ram overlay wrong");
   a_ext_abort: assert property (
      req_valid && req_addr >= EXT_BASE && req_addr <= EXT_TOP |=> res[6:2] == 5'h00 && res[1:0] != 2'h0)
      else $error("external access not aborted");
   a_fetch_periph: assert property (
      req_valid && req_fetch && req_addr >= SLOWP_BASE |=> prefetch_abort && !sel_slowp && !sel_fastp)
      else $error("peripheral fetch not aborted");
   a_abort_quiet: assert property (data_abort || prefetch_abort |-> !sel_write)
      else $error("write strobe on aborted access");
   a_idle_quiet: assert property (!req_valid |=> res == 7'h00)
      else $error("answer without request");
   a_one_answer: assert property (req_valid |=> $onehot0(res[6:2]) && res != 7'h00)
      else $error("no single answer");
endmodule
bind adr_decode adr_decode_asserts adr_decode_asserts_inst (.ref_clk, .rst, .map_wr, .map_wdata, .map_mode,
   .req_valid, .req_fetch, .req_addr, .sel_flash, .sel_sram, .sel_boot, .sel_slowp, .sel_fastp, .sel_addr,
   .sel_write, .data_abort, .prefetch_abort);

// ==== tb/adr_core_model.sv ====
// Core model: issues fetches and data accesses to the decoder
module adr_core_model (
   // Clock and answer
   input wire logic ref_clk,
   input wire logic prefetch_abort,
   // Request
   output logic req_valid,
   output logic req_write,
   output logic req_fetch,
   output logic [1:0] req_size,
   output logic [31:0] req_addr,
   // Fault carried with a fetch
   output logic fault_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      req_valid = 1'h0;
      req_write = 1'h0;
      req_fetch = 1'h0;
      req_size = 2'h0;
      req_addr = 32'h0;
      fault_reg = 1'h0;
   end
   // Flag set on any prefetch abort and held for the rest of the run
   always @(posedge ref_clk)
   begin
      if (prefetch_abort)
      begin
         fault_reg <= 1'h1;
      end
   end
   // Callers pick the access size; narrow peripheral accesses are issued too
   task automatic access(input logic f, input logic w, input logic [1:0] sz, input logic [31:0] a);
      @(negedge ref_clk);
      req_valid = 1'h1;
      req_fetch = f;
      req_write = w;
      req_size = sz;
      req_addr = a;
      @(negedge ref_clk);
      req_valid = 1'h0;
      // Idle address inverted so stale values never pass
      req_addr = ~a;
   endtask
endmodule

// ==== tb/address_decode_remap_abort_bench.sv ====
// Bench: drives core model and mode port, judges decoder answers
module address_decode_remap_abort_bench
   import adr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] FL = 32'h40, SR = 32'h20, BT = 32'h10, SP = 32'h08, FP = 32'h04, DA = 32'h02, PA = 32'h01;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic map_wr = 1'h0;
   logic [1:0] map_wdata = 2'h0;
   logic req_valid, req_write, req_fetch, fault_reg, sel_flash, sel_sram, sel_boot, sel_slowp, sel_fastp;
   logic sel_write, data_abort, prefetch_abort;
   logic [1:0] req_size, map_mode;
   logic [31:0] req_addr, sel_addr;
   logic [6:0] sel_slot;
   int mismatches = 0;
   int total_checks = 0;
   wire [31:0] res = {25'h0, sel_flash, sel_sram, sel_boot, sel_slowp, sel_fastp, data_abort, prefetch_abort};
   always #4 ref_clk = ~ref_clk;
   adr_decode adr_decode_inst (.ref_clk, .rst, .map_wr, .map_wdata, .map_mode, .req_valid, .req_write, .req_fetch,
      .req_size, .req_addr, .sel_flash, .sel_sram, .sel_boot, .sel_slowp, .sel_fastp, .sel_slot, .sel_addr,
      .sel_write, .data_abort, .prefetch_abort);
   adr_core_model adr_core_model_inst (.ref_clk, .prefetch_abort, .req_valid, .req_write, .req_fetch, .req_size,
      .req_addr, .fault_reg);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic go(input logic f, input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] e);
      adr_core_model_inst.access(f, w, sz, a);
      check("answer", res, e);
   endtask
   task automatic set_mode(input logic [1:0] m);
      @(negedge ref_clk);
      map_wr = 1'h1;
      map_wdata = m;
      @(negedge ref_clk);
      map_wr = 1'h0;
   endtask
   task automatic t_reset_mode;
      check("map_mode", 32'(map_mode), 32'(MAP_BOOT));
      set_mode(2'h3);
      check("map_mode", 32'(map_mode), 32'(MAP_BOOT));
      go(1'h1, 1'h0, SZ_WORD, 32'h0, BT);
      check("sel_addr", sel_addr, BOOT_BASE);
      go(1'h0, 1'h0, SZ_WORD, 32'h3C, BT);
      check("sel_addr", sel_addr, BOOT_BASE + 32'h3C);
      go(1'h0, 1'h0, SZ_WORD, BOOT_BASE, BT);
      $display("t_reset_mode done");
   endtask
   task automatic t_modes;
      set_mode(MAP_FLASH);
      go(1'h1, 1'h0, SZ_WORD, VEC_LAST, FL);
      check("sel_addr", sel_addr, VEC_LAST);
      go(1'h0, 1'h0, SZ_WORD, 32'h14, FL);
      check("sel_addr", sel_addr, 32'h14);
      set_mode(MAP_RAM);
      check("map_mode", 32'(map_mode), 32'(MAP_RAM));
      go(1'h0, 1'h0, SZ_WORD, 32'h3C, SR);
      check("sel_addr", sel_addr, SRAM_BASE + 32'h3C);
      go(1'h0, 1'h0, SZ_WORD, 32'h40, FL);
      go(1'h0, 1'h0, SZ_WORD, SRAM_BASE, SR);
      go(1'h0, 1'h0, SZ_WORD, BOOT_BASE, BT);
      @(negedge ref_clk);
      rst = 1'h1;
      @(negedge ref_clk);
      rst = 1'h0;
      check("map_mode", 32'(map_mode), 32'(MAP_BOOT));
      $display("t_modes done");
   endtask
   task automatic t_aborts;
      logic [31:0] bad [7] = '{32'h2_0000, 32'h4001_0000, EXT_BASE, 32'hDFFF_FFFC, 32'hE020_0000, 32'hE004_0000,
         32'hFFE0_4000};
      foreach (bad[i]) go(1'h0, 1'h0, SZ_WORD, bad[i], DA);
      go(1'h0, 1'h1, SZ_WORD, 32'hE004_0000, DA);
      check("sel_write", 32'(sel_write), 32'h0);
      go(1'h0, 1'h1, SZ_WORD, EXT_BASE, DA);
      check("sel_write", 32'(sel_write), 32'h0);
      $display("t_aborts done");
   endtask
   task automatic t_periph;
      go(1'h0, 1'h0, SZ_WORD, 32'hE000_C014, SP);
      check("sel_slot", 32'(sel_slot), 32'h3);
      check("offset", 32'(sel_addr[7:2]), 32'h5);
      go(1'h0, 1'h1, SZ_WORD, 32'hE000_D000, SP);
      check("sel_write", 32'(sel_write), 32'h1);
      check("offset", sel_addr, 32'h0);
      go(1'h0, 1'h0, SZ_WORD, 32'hFFFF_C000, FP);
      check("sel_slot", 32'(sel_slot), 32'h7F);
      go(1'h0, 1'h0, SZ_HALF, 32'hE000_0002, DA);
      go(1'h0, 1'h0, SZ_BYTE, 32'hE000_0001, DA);
      $display("t_periph done");
   endtask
   task automatic t_fetch;
      go(1'h1, 1'h0, SZ_WORD, SLOWP_BASE, PA);
      go(1'h1, 1'h0, SZ_WORD, 32'hFFFF_C000, PA);
      check("fault", 32'(fault_reg), 32'h1);
      $display("t_fetch done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge ref_clk);
      rst = 1'h0;
      t_reset_mode();
      t_modes();
      t_aborts();
      t_periph();
      t_fetch();
      tally_and_finish();
   end
   // About forty times the expected run
   initial
   begin
      #20000;
      mismatches++;
      tally_and_finish();
   end
endmodule
